// *** rtl/sjt_pkg.sv ***
// Constants and types shared by the boundary-scan test access port
package sjt_pkg;

  // ****************************************
  // Scan path lengths
  // ****************************************
  localparam int IR_LEN = 3;
  localparam int BYP_LEN = 1;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN = 109;
  localparam int PAD_CNT = 108;

  // ****************************************
  // Identification word layout
  // ****************************************
  localparam int ID_REV_MSB = 31;
  localparam int ID_REV_LSB = 29;
  localparam int ID_CFG_MSB = 28;
  localparam int ID_CFG_LSB = 12;
  localparam int ID_MFR_MSB = 11;
  localparam int ID_MFR_LSB = 1;
  localparam logic ID_START_BIT = 1'h1;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic BYP_CAPTURE_VAL = 1'h0;
  localparam logic INTERNAL_CELL_VAL = 1'h0;

  // ****************************************
  // Controller states, one-hot
  // ****************************************
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } sjt_state_t;

endpackage : sjt_pkg

// *** rtl/sjt_sync.sv ***
// Two-flop synchroniser for a bundle of independent levels
`timescale 1ns/100ps
module sjt_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end

endmodule : sjt_sync

// *** rtl/sjt_tap.sv ***
// Boundary-scan test access port: controller, scan paths, output-disable crossing
`timescale 1ns/100ps

module sjt_tap
  import sjt_pkg::*;
#(
  parameter logic [2:0] ID_REVISION = 3'h1,       // Arbitrary value
  parameter logic [16:0] ID_CONFIG = 17'h0a5a5,   // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2aa,      // Arbitrary value
  parameter logic [PAD_CNT-1:0] NC_MASK = '0
) (
  // System clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Test port pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tms_drv_i,
  input wire logic tdi_i,
  input wire logic tdi_drv_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Package pad levels, exit order 1 at bit 0
  input wire logic [PAD_CNT-1:0] pad_i,
  // Data output disable toward the memory core
  output logic dq_hiz_o
);

  // ****************************************
  // Pin conditioning and test-clock reset
  // ****************************************
  logic tms_eff;
  logic tdi_eff;
  logic [0:0] nrst_tck;
  logic tap_rst;
  logic [PAD_CNT-1:0] pad_sync;

  // Undriven pins read as one, as a pull-up would give
  assign tms_eff = tms_i | ~tms_drv_i;
  assign tdi_eff = tdi_i | ~tdi_drv_i;

  // Power-up reset brought into the test-clock domain; no test-reset pin exists
  sjt_sync #(.W(1)) u_rst_sync (
    .clk_i(tck_i),
    .d_i(nrst_i),
    .q_o(nrst_tck)
  );
  assign tap_rst = ~nrst_tck[0];

  // Pads are asynchronous to the test clock
  sjt_sync #(.W(PAD_CNT)) u_pad_sync (
    .clk_i(tck_i),
    .d_i(pad_i),
    .q_o(pad_sync)
  );

  // ****************************************
  // Controller
  // ****************************************
  sjt_state_t state;
  sjt_state_t next_state;

  always_comb begin
    case (state)
      ST_TLR: next_state = tms_eff ? ST_TLR : ST_RTI;
      ST_RTI: next_state = tms_eff ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = tms_eff ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_eff ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms_eff ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms_eff ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms_eff ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms_eff ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = tms_eff ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = tms_eff ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_eff ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms_eff ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms_eff ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms_eff ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms_eff ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = tms_eff ? ST_SEL_DR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      state <= ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Instruction path and decode
  // ****************************************
  logic [IR_LEN-1:0] instr_shift;
  logic [IR_LEN-1:0] tap_instruction;
  logic instr_bit_high;
  logic instr_bit_mid;
  logic instr_bit_low;
  logic sel_bypass;
  logic sel_idcode;
  logic sel_boundary;
  logic hiz_req;
  logic [IR_LEN-1:0] next_instr;

  always_ff @(posedge tck_i) begin
    if (state == ST_CAP_IR) begin
      instr_shift <= IR_CAPTURE_VAL;
    end else if (state == ST_SHIFT_IR) begin
      instr_shift <= {tdi_eff, instr_shift[IR_LEN-1:1]};
    end
  end

  // Decoded one edge ahead: the test clock may stop right after an update,
  // so the output disable must already follow at the update edge itself
  assign next_instr = (state == ST_TLR) ? INS_IDCODE :
                      (state == ST_UPD_IR) ? instr_shift : tap_instruction;

  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      tap_instruction <= INS_IDCODE;
    end else begin
      tap_instruction <= next_instr;
    end
  end

  assign instr_bit_high = tap_instruction[2];
  assign instr_bit_mid = tap_instruction[1];
  assign instr_bit_low = tap_instruction[0];
  // Reserved codes fall to bypass so the port never stalls the chain
  assign sel_idcode = {instr_bit_high, instr_bit_mid, instr_bit_low} == INS_IDCODE;
  assign sel_boundary = tap_instruction == INS_EXTEST || tap_instruction == INS_SAMPLE_Z
                        || tap_instruction == INS_SAMPLE;
  assign sel_bypass = !sel_idcode && !sel_boundary;
  // Extest and sample-z float the data outputs; plain sample does not
  assign hiz_req = next_instr == INS_EXTEST || next_instr == INS_SAMPLE_Z;

  // ****************************************
  // Data paths
  // ****************************************
  logic tap_bypass_cell;
  logic [ID_LEN-1:0] device_identification;
  logic [ID_LEN-1:0] id_word;
  logic [BSR_LEN-1:0] pad_scan_chain;
  logic [BSR_LEN-1:0] pad_capture;
  logic cap_dr;
  logic sh_dr;

  assign cap_dr = state == ST_CAP_DR;
  assign sh_dr = state == ST_SHIFT_DR;
  assign id_word = {ID_REVISION, ID_CONFIG, ID_MAKER, ID_START_BIT};
  // Only pad levels are captured; the internal cell holds a constant
  assign pad_capture = {INTERNAL_CELL_VAL, pad_sync & ~NC_MASK};

  always_ff @(posedge tck_i) begin
    if (cap_dr && sel_bypass) begin
      tap_bypass_cell <= BYP_CAPTURE_VAL;
    end else if (sh_dr && sel_bypass) begin
      tap_bypass_cell <= tdi_eff;
    end
  end

  always_ff @(posedge tck_i) begin
    if (cap_dr && sel_idcode) begin
      device_identification <= id_word;
    end else if (sh_dr && sel_idcode) begin
      device_identification <= {tdi_eff, device_identification[ID_LEN-1:1]};
    end
  end

  always_ff @(posedge tck_i) begin
    if (cap_dr && sel_boundary) begin
      pad_scan_chain <= pad_capture;
    end else if (sh_dr && sel_boundary) begin
      pad_scan_chain <= {tdi_eff, pad_scan_chain[BSR_LEN-1:1]};
    end
  end

  // ****************************************
  // Serial output on the falling edge
  // ****************************************
  logic shifting;
  logic dr_bit;
  logic next_tdo;

  assign shifting = state == ST_SHIFT_DR || state == ST_SHIFT_IR;
  assign dr_bit = sel_idcode ? device_identification[0] :
                  sel_boundary ? pad_scan_chain[0] : tap_bypass_cell;
  assign next_tdo = (state == ST_SHIFT_IR) ? instr_shift[0] : dr_bit;

  // Falling-edge launch gives the tester half a period of setup
  always_ff @(negedge tck_i) begin
    if (tap_rst) begin
      tdo_o <= 1'h0;
      tdo_oe_o <= 1'h0;
    end else begin
      tdo_o <= next_tdo;
      tdo_oe_o <= shifting;
    end
  end

  // ****************************************
  // Output disable into the system domain
  // ****************************************
  logic hiz_tck;
  logic [0:0] hiz_sync;

  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      hiz_tck <= 1'h0;
    end else begin
      hiz_tck <= hiz_req;
    end
  end

  sjt_sync #(.W(1)) u_hiz_sync (
    .clk_i(mclk_i),
    .d_i(hiz_tck),
    .q_o(hiz_sync)
  );

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dq_hiz_o <= 1'h0;
    end else begin
      dq_hiz_o <= hiz_sync[0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_FIVE_ONES_RESET: assert property (@(posedge tck_i) disable iff (tap_rst)
    tms_eff [*5] |=> state == ST_TLR) else $error("Five mode-select ones did not reset");

  AST_BYPASS_CLEARS: assert property (@(posedge tck_i) disable iff (tap_rst)
    cap_dr && sel_bypass |=> !tap_bypass_cell) else $error("Bypass cell not cleared");

  AST_BYPASS_HOLDS: assert property (@(posedge tck_i) disable iff (tap_rst)
    sh_dr && sel_bypass ##1 state == ST_EXIT1_DR |=> tap_bypass_cell == $past(tdi_eff, 2))
    else $error("Bypass cell lost last shifted bit");

  AST_ID_CAPTURE: assert property (@(posedge tck_i) disable iff (tap_rst)
    cap_dr && sel_idcode |=> device_identification[0] == ID_START_BIT
      && device_identification[ID_REV_MSB:ID_REV_LSB] == ID_REVISION
      && device_identification[ID_CFG_MSB:ID_CFG_LSB] == ID_CONFIG
      && device_identification[ID_MFR_MSB:ID_MFR_LSB] == ID_MAKER)
    else $error("Identification word wrong");

  AST_ID_SHIFT_IN: assert property (@(posedge tck_i) disable iff (tap_rst)
    sh_dr && sel_idcode |=> device_identification[ID_LEN-1] == $past(tdi_eff))
    else $error("Data-in not entering identification path");

  AST_SAMPLE_Z_FLOATS: assert property (@(posedge tck_i) disable iff (tap_rst)
    state == ST_UPD_IR && instr_shift == INS_SAMPLE_Z |=> hiz_tck)
    else $error("Sample-z did not float outputs");

  AST_EXTEST_FLOATS: assert property (@(posedge tck_i) disable iff (tap_rst)
    state == ST_UPD_IR && instr_shift == INS_EXTEST |=> hiz_tck)
    else $error("Extest did not float outputs");

  AST_SAMPLE_NORMAL: assert property (@(posedge tck_i) disable iff (tap_rst)
    state == ST_UPD_IR && instr_shift == INS_SAMPLE |=> !hiz_tck)
    else $error("Sample floated outputs");

  AST_CHAIN_PADS_ONLY: assert property (@(posedge tck_i) disable iff (tap_rst)
    cap_dr && sel_boundary |=> !pad_scan_chain[BSR_LEN-1]
      && (pad_scan_chain[PAD_CNT-1:0] & NC_MASK) == '0
      && pad_scan_chain[PAD_CNT-1:0] == $past(pad_sync & ~NC_MASK))
    else $error("Boundary capture not pad levels");

  AST_TDO_IDLE_OFF: assert property (@(negedge tck_i) disable iff (tap_rst)
    !shifting |=> !tdo_oe_o) else $error("Data-out driven outside shift");

  AST_TDO_SHIFT_ON: assert property (@(negedge tck_i) disable iff (tap_rst)
    shifting |=> tdo_oe_o) else $error("Data-out not driven during shift");

  AST_HIZ_CROSSES: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(hiz_sync[0]) |=> dq_hiz_o) else $error("Output disable not passed on");

  COV_BYPASS_SHIFT: cover property (@(posedge tck_i) sh_dr && sel_bypass);
  COV_ID_READ: cover property (@(posedge tck_i) cap_dr && sel_idcode ##1 sh_dr);
  COV_HIZ: cover property (@(posedge mclk_i) dq_hiz_o);
  COV_CHAIN_SHIFT: cover property (@(posedge tck_i) sh_dr && sel_boundary);

endmodule : sjt_tap

// *** verification/sjt_tester.sv ***
// Test controller model that drives the boundary-scan port from the far side
`timescale 1ns/100ps
module sjt_tester (
  // Test port pins
  output logic tck_o,
  output logic tms_o,
  output logic tms_drv_o,
  output logic tdi_o,
  output logic tdi_drv_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  // Scan results
  output logic res_valid_o,
  output logic [127:0] res_o
);
  // Test clock stands still low outside frames
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tms_drv_o = 1'h1;
    tdi_o = 1'h1;
    tdi_drv_o = 1'h1;
    res_valid_o = 1'h0;
    res_o = '0;
  end

  // ****************************************
  // One test clock period
  // ****************************************
  task automatic cycle(input logic m, input logic mdrv, input logic d, input logic ddrv,
                       output logic q);
    tms_drv_o <= mdrv;
    // A released line toggles so that a stale level cannot pass for a one
    tms_o <= mdrv ? m : ~tms_o;
    tdi_drv_o <= ddrv;
    tdi_o <= ddrv ? d : ~tdi_o;
    #62.5;
    tck_o = 1'h1;
    // An undriven data-out reads as high impedance
    q = tdo_oe_i ? tdo_i : 1'hz;
    #62.5;
    tck_o = 1'h0;
  endtask : cycle

  task automatic tlr(input int n, input logic drv);
    logic q;
    repeat (n) cycle(1'h1, drv, 1'h0, 1'h1, q);
  endtask : tlr

  // Starts and ends in run-test/idle; data enters and leaves least significant bit first
  task automatic scan(input logic ir, input int len, input logic [127:0] din, input logic ddrv);
    logic q;
    logic [127:0] got;
    got = '0;
    cycle(1'h0, 1'h1, 1'h0, 1'h1, q);
    cycle(1'h1, 1'h1, 1'h0, 1'h1, q);
    if (ir) begin
      cycle(1'h1, 1'h1, 1'h0, 1'h1, q);
    end
    cycle(1'h0, 1'h1, 1'h0, 1'h1, q);
    cycle(1'h0, 1'h1, 1'h0, 1'h1, q);
    for (int i = 0; i < len; i++) begin
      cycle(i == len - 1, 1'h1, din[i], ddrv, q);
      got[i] = q;
    end
    cycle(1'h1, 1'h1, 1'h0, 1'h1, q);
    cycle(1'h0, 1'h1, 1'h0, 1'h1, q);
    res_o = got;
    res_valid_o = 1'h1;
    #10;
    res_valid_o = 1'h0;
  endtask : scan
endmodule : sjt_tester

// *** verification/sjt_tb.sv ***
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
module tb;
  import sjt_pkg::*;
  localparam logic [2:0] REV = 3'h1;
  localparam logic [16:0] CFG = 17'h0a5a5;
  localparam logic [10:0] MAKER = 11'h2aa;
  localparam logic [31:0] ID_WORD = {REV, CFG, MAKER, ID_START_BIT};
  // Only documented codes are ever loaded
  localparam logic [2:0] CODES [5] = '{INS_EXTEST, INS_IDCODE, INS_SAMPLE_Z, INS_SAMPLE,
                                       INS_BYPASS};
  logic mclk_i, nrst_i, tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, dq_hiz, res_valid;
  logic [PAD_CNT-1:0] pad;
  logic [127:0] res, rnd;
  logic [127:0] exp_q[$];
  int miscompares = 0;
  int tests_run = 0;

  always #2 mclk_i = ~mclk_i;

  sjt_tap #(.ID_REVISION(REV), .ID_CONFIG(CFG), .ID_MAKER(MAKER), .NC_MASK('0)) dut_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tms_drv_i(tms_drv),
    .tdi_i(tdi), .tdi_drv_i(tdi_drv), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_i(pad),
    .dq_hiz_o(dq_hiz));

  sjt_tester tester_u (
    .tck_o(tck), .tms_o(tms), .tms_drv_o(tms_drv), .tdi_o(tdi), .tdi_drv_o(tdi_drv),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe), .res_valid_o(res_valid), .res_o(res));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string nm, input logic [127:0] exp, input logic [127:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  always @(posedge res_valid) begin
    check("scan_out", exp_q.pop_front(), res);
  end

  task automatic dr(input int len, input logic [127:0] din, input logic [127:0] exp,
                    input logic ddrv);
    exp_q.push_back(exp);
    tester_u.scan(1'h0, len, din, ddrv);
  endtask : dr

  task automatic ir_load(input logic [2:0] c);
    exp_q.push_back({125'h0, IR_CAPTURE_VAL});
    tester_u.scan(1'h1, IR_LEN, {125'h0, c}, 1'h1);
  endtask : ir_load

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mclk_i = 1'h0;
    nrst_i = 1'h0;
    pad = '0;
    void'($urandom(32'h7c04));
    fork
      repeat (5) @(posedge mclk_i);
      tester_u.tlr(3, 1'h1);
    join
    @(posedge mclk_i);
    nrst_i <= 1'h1;
    tester_u.tlr(3, 1'h1);
    dr(ID_LEN, '0, {96'h0, ID_WORD}, 1'h1);
    rnd = {$urandom, $urandom, $urandom, $urandom};
    dr(64, rnd, {64'h0, rnd[31:0], ID_WORD}, 1'h1);
    foreach (CODES[k]) begin
      rnd = {$urandom, $urandom, $urandom, $urandom};
      @(posedge mclk_i);
      pad <= rnd[PAD_CNT-1:0];
      ir_load(CODES[k]);
      repeat (4) @(posedge mclk_i);
      check("dq_hiz", {127'h0, CODES[k] == INS_EXTEST || CODES[k] == INS_SAMPLE_Z},
            {127'h0, dq_hiz});
      check("tdo_oe_idle", 128'h0, {127'h0, tdo_oe});
      case (CODES[k])
        INS_IDCODE: dr(ID_LEN, '0, {96'h0, ID_WORD}, 1'h1);
        INS_BYPASS: dr(8, rnd, {120'h0, rnd[6:0], BYP_CAPTURE_VAL}, 1'h1);
        default: dr(BSR_LEN, rnd, {19'h0, INTERNAL_CELL_VAL, rnd[PAD_CNT-1:0]}, 1'h1);
      endcase
    end
    // Undriven data-in must shift in ones behind the cleared bypass cell
    dr(4, '0, {124'h0, 4'he}, 1'h0);
    // Undriven mode-select must walk the controller back to reset
    tester_u.tlr(5, 1'h0);
    dr(ID_LEN, '0, {96'h0, ID_WORD}, 1'h1);
    repeat (4) @(posedge mclk_i);
    check("queue_left", 128'h0, 128'(exp_q.size()));
    end_of_test();
  end

  // Whole run takes about 77 us of test clock
  initial begin
    #250000;
    miscompares++;
    end_of_test();
  end
endmodule : tb
